// ---- rtl/mtrd_decode.sv ----
// decode and execute of register, timer and status opcodes
`timescale 1ns/1ps
module mtrd_decode
  import mtrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [7:0] opcode,
  input wire logic eventInputPin,
  output logic opReady,
  output logic [7:0] accOut,
  output logic [7:0] counterOut,
  output logic [7:0] programStatusWord,
  output logic countIrqEnable,
  output logic counterOverflow,
  output logic [63:0] workingRegisters
);
`include "mtrd_params.svh"

  logic [7:0] wreg_reg [0:7];
  logic [7:0] acc_reg;
  logic [7:0] cnt_reg;
  logic [7:0] status_reg;
  logic irqEn_reg;
  logic ovf_reg;
  logic [4:0] pre_reg;
  logic pinLast_reg;
  logic ready_reg;
  mtrd_mode_t mode_reg;
  mtrd_state_t state_reg;
  mtrd_state_t state_next;
  logic [7:0] wregNext;
  logic [7:0] ramRd;
  mtrd_ram_req_t ramReq;

  // single-cycle opcode decode
  function automatic logic isOp(input logic [7:0] op, input logic [7:0] c);
    isOp = (op == c);
  endfunction : isOp

  wire take = opValid && ready_reg && state_reg == MTRD_EXEC;
  wire [2:0] rSel = opcode[2:0];
  wire doInc = take && opcode[7:3] == `MTRD_OP_INC_R_HI;
  wire doDec = take && opcode[7:3] == `MTRD_OP_DEC_R_HI;
  wire doInd = take && opcode[7:1] == `MTRD_OP_INC_I_HI;
  wire doRdCnt = take && isOp(opcode, `MTRD_OP_RD_CNT);
  wire doLdCnt = take && isOp(opcode, `MTRD_OP_LD_CNT);
  wire doStartT = take && isOp(opcode, `MTRD_OP_START_T);
  wire doStartE = take && isOp(opcode, `MTRD_OP_START_E);
  wire doHalt = take && isOp(opcode, `MTRD_OP_HALT);
  wire doIrqOn = take && isOp(opcode, `MTRD_OP_IRQ_ON);
  wire doIrqOff = take && isOp(opcode, `MTRD_OP_IRQ_OFF);
  wire doRdStatus = take && isOp(opcode, `MTRD_OP_RD_STATUS);

  // indirect pointer latched with the opcode
  logic [6:0] ptr_reg;
  wire [6:0] ptrNow = wreg_reg[{2'h0, opcode[0]}][6:0];

  // count tick: prescaler wrap in timer mode, pin fall in event mode
  wire preWrap = pre_reg == `MTRD_PRESCALE;
  wire pinFall = pinLast_reg && !eventInputPin;
  wire tick = (mode_reg == MTRD_TIMING && preWrap)
    || (mode_reg == MTRD_EVENTS && pinFall);

  // working register next value for inc/dec
  assign wregNext = doInc ? wreg_reg[rSel] + `MTRD_BYTE_ONE
    : wreg_reg[rSel] - `MTRD_BYTE_ONE;

  // memory port: read pointer, then write back the incremented byte
  always_comb
  begin
    ramReq.we = state_reg == MTRD_IND_WR;
    ramReq.addr = doInd ? ptrNow : ptr_reg;
    ramReq.data = ramRd + `MTRD_BYTE_ONE;
  end

  mtrd_data_ram u_ram (
    .clk(clk),
    .req(ramReq),
    .rdData(ramRd)
  );

  // indirect increment sequencer keeps one opcode in flight
  always_comb
  begin
    unique case (state_reg)
      MTRD_EXEC: state_next = doInd ? MTRD_IND_RD : MTRD_EXEC;
      MTRD_IND_RD: state_next = MTRD_IND_WR;
      MTRD_IND_WR: state_next = MTRD_EXEC;
      default: state_next = MTRD_EXEC;
    endcase
  end

  // sequencer and handshake; ready drops while memory op completes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= MTRD_EXEC;
      ready_reg <= 1'b1;
      ptr_reg <= `MTRD_PTR_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= state_next == MTRD_EXEC && !doInd;
      if (doInd)
      begin
        ptr_reg <= ptrNow;
      end
    end
  end

  // working registers; written in the cycle the opcode is taken
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_wreg
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          wreg_reg[gi] <= `MTRD_BYTE_ZERO;
        end
        else if ((doInc || doDec) && rSel == 3'(gi))
        begin
          wreg_reg[gi] <= wregNext;
        end
      end
      assign workingRegisters[gi*8 +: 8] = wreg_reg[gi];
    end
  endgenerate

  // accumulator transfers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_reg <= `MTRD_BYTE_ZERO;
    end
    else if (doRdCnt)
    begin
      acc_reg <= cnt_reg;
    end
    else if (doRdStatus)
    begin
      acc_reg <= status_reg;
    end
  end

  // counter mode control
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= MTRD_STOPPED;
      irqEn_reg <= 1'b0;
    end
    else
    begin
      if (doStartT)
      begin
        mode_reg <= MTRD_TIMING;
      end
      else if (doStartE)
      begin
        mode_reg <= MTRD_EVENTS;
      end
      else if (doHalt)
      begin
        mode_reg <= MTRD_STOPPED;
      end
      if (doIrqOn)
      begin
        irqEn_reg <= 1'b1;
      end
      else if (doIrqOff)
      begin
        irqEn_reg <= 1'b0;
      end
    end
  end

  // counter and prescaler; load from acc wins over a tick
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= `MTRD_BYTE_ZERO;
      pre_reg <= `MTRD_PRE_ZERO;
      pinLast_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      pinLast_reg <= eventInputPin;
      // prescaler restarts on timer start so first tick is a full period
      pre_reg <= (doStartT || mode_reg != MTRD_TIMING) ? `MTRD_PRE_ZERO
        : pre_reg + `MTRD_PRE_ONE;
      ovf_reg <= 1'b0;
      if (doLdCnt)
      begin
        cnt_reg <= acc_reg;
      end
      else if (tick)
      begin
        cnt_reg <= cnt_reg + `MTRD_BYTE_ONE;
        ovf_reg <= cnt_reg == `MTRD_BYTE_MAX;
      end
    end
  end

  // status word is untouched by these opcodes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_reg <= `MTRD_STATUS_RESET;
    end
  end

  assign opReady = ready_reg;
  assign accOut = acc_reg;
  assign counterOut = cnt_reg;
  assign programStatusWord = status_reg;
  assign countIrqEnable = irqEn_reg;
  assign counterOverflow = ovf_reg;
endmodule : mtrd_decode

// ---- rtl/mtrd_params.svh ----
// constants for the timer and register op decode block
`ifndef MTRD_PARAMS_SVH
`define MTRD_PARAMS_SVH
`define MTRD_OP_INC_R_HI 5'h03
`define MTRD_OP_INC_I_HI 7'h08
`define MTRD_OP_DEC_R_HI 5'h19
`define MTRD_OP_RD_CNT 8'h42
`define MTRD_OP_LD_CNT 8'h62
`define MTRD_OP_START_T 8'h55
`define MTRD_OP_START_E 8'h45
`define MTRD_OP_HALT 8'h65
`define MTRD_OP_IRQ_ON 8'h25
`define MTRD_OP_IRQ_OFF 8'h35
`define MTRD_OP_RD_STATUS 8'hC7
`define MTRD_PRESCALE 5'h1F
`define MTRD_STATUS_RESET 8'h08
`define MTRD_BYTE_ZERO 8'h00
`define MTRD_BYTE_ONE 8'h01
`define MTRD_BYTE_MAX 8'hFF
`define MTRD_PRE_ZERO 5'h00
`define MTRD_PRE_ONE 5'h01
`define MTRD_PTR_ZERO 7'h00
`define MTRD_RAM_AW 7
`define MTRD_RAM_WORDS 128
`endif

// ---- rtl/mtrd_pkg.sv ----
// types shared by the timer and register op decode block
package mtrd_pkg;
  typedef enum logic [1:0] {MTRD_STOPPED, MTRD_TIMING, MTRD_EVENTS}
    mtrd_mode_t;
  typedef enum logic [1:0] {MTRD_EXEC, MTRD_IND_RD, MTRD_IND_WR}
    mtrd_state_t;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } mtrd_ram_req_t;
endpackage : mtrd_pkg

// ---- rtl/mtrd_data_ram.sv ----
// data memory with registered read port
`timescale 1ns/1ps
module mtrd_data_ram
  import mtrd_pkg::*;
(
  input wire logic clk,
  input wire mtrd_ram_req_t req,
  output logic [7:0] rdData
);
`include "mtrd_params.svh"
  logic [7:0] mem [0:`MTRD_RAM_WORDS-1];

  // read-before-write port, read data always registered
  always_ff @(posedge clk)
  begin
    if (req.we)
    begin
      mem[req.addr] <= req.data;
    end
    rdData <= mem[req.addr];
  end
endmodule : mtrd_data_ram

// ---- testbench/mtrd_monitor.sv ----
// assertions on the decode block ports
`timescale 1ns/1ps
module mtrd_monitor (
  input logic clk,
  input logic rst_n,
  input logic opValid,
  input logic [7:0] opcode,
  input logic opReady,
  input logic [7:0] accOut,
  input logic [7:0] counterOut,
  input logic [7:0] programStatusWord,
  input logic countIrqEnable,
  input logic counterOverflow,
  input logic [63:0] workingRegisters
);
  logic [2:0] idx;
  logic [7:0] old;
  wire tk = opValid && opReady;
  wire [7:0] now = workingRegisters[idx*8 +: 8];
  // remember the addressed register, so the check sees the cause
  always_ff @(posedge clk)
  begin
    idx <= opcode[2:0];
    old <= workingRegisters[opcode[2:0]*8 +: 8];
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_inc;
    tk && opcode[7:3] == 5'h03 |=> now == old + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_dec;
    tk && opcode[7:3] == 5'h19 |=> now == old - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_rdc;
    tk && opcode == 8'h42 |=> accOut == $past(counterOut);
  endproperty
  a_rdc: assert property (p_rdc) else $error("rdc");
  property p_ldc;
    tk && opcode == 8'h62 |=> counterOut == $past(accOut);
  endproperty
  a_ldc: assert property (p_ldc) else $error("ldc");
  property p_ion;
    tk && opcode == 8'h25 |=> countIrqEnable;
  endproperty
  a_ion: assert property (p_ion) else $error("ion");
  property p_iof;
    tk && opcode == 8'h35 |=> !countIrqEnable;
  endproperty
  a_iof: assert property (p_iof) else $error("iof");
  property p_status;
    tk && opcode == 8'hC7 |=> accOut == $past(programStatusWord);
  endproperty
  a_status: assert property (p_status) else $error("status");
  // halted counter holds unless a load follows the halt
  property p_halt;
    tk && opcode == 8'h65 ##1 !(tk && opcode == 8'h62)
      |=> $stable(counterOut);
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  // overflow pulse only right after a wrap from FF to 00
  property p_ovf;
    counterOverflow |-> counterOut == 8'h00 && $past(counterOut) == 8'hFF;
  endproperty
  a_ovf: assert property (p_ovf) else $error("ovf");
  property p_ind;
    tk && opcode[7:1] == 7'h08 |=> !opReady [*2] ##1 opReady;
  endproperty
  a_ind: assert property (p_ind) else $error("ind");
endmodule : mtrd_monitor

// ---- testbench/mtrd_prog_mem.sv ----
// program memory model that feeds opcode bytes
`timescale 1ns/1ps
module mtrd_prog_mem (
  input logic clk,
  input logic opReady,
  output logic opValid = 1'b0,
  output logic [7:0] opcode = 8'h00
);
  logic [7:0] q[$];
  // a byte leaves only at an edge that takes it
  always @(posedge clk)
    if (opValid && opReady)
      void'(q.pop_front());
  // held until taken; idle bus keeps changing, never a stale byte
  always @(negedge clk)
  begin
    opValid <= q.size() > 0;
    opcode <= q.size() > 0 ? q[0] : ~opcode;
  end
endmodule : mtrd_prog_mem

// ---- testbench/tb.sv ----
// self-checking bench for the decode block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic eventInputPin = 1'b1;
  logic opValid, opReady, countIrqEnable, ie, counterOverflow;
  logic [7:0] opcode, accOut, counterOut, programStatusWord, b;
  logic [7:0] base [8] = '{8'h18, 8'hC8, 8'hC7, 8'h35, 8'h42, 8'h62,
    8'h10, 8'h00};
  logic [63:0] workingRegisters, e;
  logic [31:0] seed = 32'h4807;
  logic [2:0] k, r;
  int error_cnt = 0;
  int checks = 0;
  int wr[8], acc, cnt, ovf, ovfSeen, nFall;
  // free-running clock
  always #5 clk = ~clk;
  // count overflow pulses; each stands for one whole cycle
  always @(negedge clk)
    if (counterOverflow === 1'b1)
      ovfSeen++;
  mtrd_prog_mem mem (.clk, .opReady, .opValid, .opcode);
  mtrd_decode DUT (.clk, .rst_n, .opValid, .opcode, .eventInputPin,
    .opReady, .accOut, .counterOut, .programStatusWord, .countIrqEnable,
    .counterOverflow, .workingRegisters);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task chk(input logic [63:0] g, input logic [63:0] x);
    checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("MISMATCH %0t %h %h", $time, g, x);
    end
  endtask : chk
  task close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // model image against every visible register but opReady
  task state;
    for (int i = 0; i < 8; i++)
      e[i*8 +: 8] = wr[i][7:0];
    chk(workingRegisters, e);
    chk(accOut, acc[7:0]);
    chk(counterOut, cnt[7:0]);
    chk(countIrqEnable, ie);
    chk(programStatusWord, 8'h08);
    chk(ovfSeen, ovf);
  endtask : state
  // bounded wait, a lost byte shows up as a mismatch
  task op(input logic [7:0] v);
    mem.q.push_back(v);
    for (int n = 0; n < 9 && mem.q.size() > 0; n++)
      @(negedge clk);
  endtask : op
  task pulse(input int n);
    repeat (n)
    begin
      eventInputPin = 1'b0;
      repeat (3) @(negedge clk);
      eventInputPin = 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask : pulse
  initial
  begin
    ie = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    state();
    // random opcodes, counter stopped so the model stays exact
    repeat (80)
    begin
      seed = lfsr(seed);
      k = seed[2:0];
      r = seed[5:3];
      b = base[k] | {5'h00, k < 2 ? r : k == 6 ? {2'h0, r[0]} : 3'h0};
      if (k == 3)
        b[4] = ~seed[6];
      op(b);
      case (k)
        0: wr[r] = (wr[r] + 1) % 256;
        1: wr[r] = (wr[r] + 255) % 256;
        2: acc = 8;
        3: ie = seed[6];
        4: acc = cnt;
        5: cnt = acc;
        default: ;
      endcase
      state();
    end
    op(8'h55);
    repeat (144) @(negedge clk);
    op(8'h65);
    ovf += (cnt + 4) / 256;
    cnt = (cnt + 4) % 256;
    state();
    repeat (40) @(negedge clk);
    state();
    nFall = 261 - cnt; // enough falls to wrap the counter once
    op(8'h45);
    pulse(nFall);
    op(8'h65);
    ovf += (cnt + nFall) / 256;
    cnt = (cnt + nFall) % 256;
    state();
    pulse(2);
    state();
    close_out();
  end
  // watchdog for a hang
  initial
  begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule : tb
bind mtrd_decode mtrd_monitor u_mon (.clk, .rst_n, .opValid, .opcode,
  .opReady, .accOut, .counterOut, .programStatusWord, .countIrqEnable,
  .counterOverflow, .workingRegisters);
